// ---- verilog/apdu_packer.v ----
// Packs header fields then message octets into a numbered octet stream.
// Assumes the source keeps field order and the sink uses valid/ready.
`timescale 1ns/10ps
`include "apdu_map.vh"

// Behaviour
// R1: header octets first, then message octets
// R2: field bit 0 into lowest free bit
// R3: overflowing bits continue into next octet
// R4: fields packed in order without gaps
// R5: grouped fields packed group by group
// R6: final octet remainder padded with zero
// R7: header padded to octet boundary alone
// R8: source supplies message already octet padded
// R9: octets numbered from zero in order
// R10: each completed octet handed downstream
// R11: output is plain octets plus number, first, last and part flags
// R12: valid/ready handshake on both sides
module apdu_packer #(
   parameter FW = `APDU_FIELD_MAX,
   parameter NW = `APDU_OCTNUM_BITS
) (
   // Clock and reset
   input  wire          CORE_CLK,
   input  wire          RST_N,
   // Field source
   input  wire          FLD_VALID,
   output reg           FLD_READY,
   input  wire [FW-1:0] FLD_VALUE,
   input  wire [5:0]    FLD_WIDTH,
   input  wire          FLD_PART,
   input  wire          FLD_LAST,
   // Octet sink
   output reg           OCT_VALID,
   input  wire          OCT_READY,
   output reg  [7:0]    OCT_DATA,
   output reg  [NW-1:0] OCT_NUM,
   output reg           OCT_FIRST,
   output reg           OCT_LAST,
   output reg           OCT_PART
);
   // Controller states
   localparam S_IDLE = 2'h0;
   localparam S_PACK = 2'h1;
   localparam S_EMIT = 2'h2;

   // Octet geometry
   localparam [3:0] OCT_FULL  = 4'h8;
   localparam [3:0] FILL_NONE = 4'h0;
   localparam [5:0] LEFT_NONE = 6'h00;

   // Controller
   reg  [1:0]    state_r;
   reg  [1:0]    state_nxt;
   reg           started_r;
   reg           started_nxt;
   // Field being packed
   reg  [FW-1:0] val_r;
   reg  [FW-1:0] val_nxt;
   reg  [5:0]    left_r;
   reg  [5:0]    left_nxt;
   reg           last_r;
   reg           last_nxt;
   reg           part_r;
   reg           part_nxt;
   // Octet under assembly
   reg  [7:0]    byte_r;
   reg  [7:0]    byte_nxt;
   reg  [3:0]    fill_r;
   reg  [3:0]    fill_nxt;
   // Next values of the registered outputs
   reg           fld_ready_nxt;
   reg           oct_valid_nxt;
   reg  [7:0]    oct_data_nxt;
   reg  [NW-1:0] oct_num_nxt;
   reg           oct_first_nxt;
   reg           oct_last_nxt;
   reg           oct_part_nxt;
   // Datapath
   wire [7:0]    mrg_byte;
   wire [3:0]    mrg_fill;
   wire [3:0]    room;
   wire [3:0]    take;
   wire [NW-1:0] num;
   wire          fld_acc;
   wire          oct_acc;
   wire          unit_end;
   wire          fld_done;
   wire          oct_full;
   wire          close_now;
   wire          cnt_clear;

   // Bits to move this cycle: smaller of room and bits left
   function [3:0] min_take;
      input [3:0] rm;
      input [5:0] lf;
      begin
         if ({2'h0, rm} < lf) begin
            min_take = rm;
         end else begin
            min_take = lf[3:0];
         end
      end
   endfunction

   // Chunk moved now is the tail of the field
   function ends_field;
      input [5:0] lf;
      input [3:0] tk;
      begin
         ends_field = (lf == {2'h0, tk});
      end
   endfunction

   // Bits still owed after this chunk
   function [5:0] left_after;
      input [5:0] lf;
      input [3:0] tk;
      begin
         left_after = lf - {2'h0, tk};
      end
   endfunction

   assign room      = OCT_FULL - fill_r;
   assign take      = min_take(room, left_r);
   assign fld_acc   = FLD_VALID & FLD_READY;
   assign oct_acc   = OCT_VALID & OCT_READY;
   assign unit_end  = last_r & part_r;
   // Width 0 finishes at once and moves no bits
   assign fld_done  = ends_field(left_r, take);
   assign oct_full  = (mrg_fill == OCT_FULL);
   // R6: a part's tail octet closes early
   assign close_now = oct_full | (fld_done & last_r & (mrg_fill != FILL_NONE));
   assign cnt_clear = oct_acc & OCT_LAST;

   // R2: LSB into lowest free bit
   apdu_field_merge u_merge (
      .cur_byte (byte_r),
      .fill     (fill_r),
      .chunk    (val_r[7:0]),
      .take_cnt (take),
      .new_byte (mrg_byte),
      .new_fill (mrg_fill)
   );

   // R9: numbering from zero
   apdu_octet_counter #(.W(NW)) u_cnt (
      .clk     (CORE_CLK),
      .rst_n   (RST_N),
      .clear   (cnt_clear),
      .inc     (oct_acc),
      .count_r (num)
   );

   // Next-state and output decode
   always @* begin
      state_nxt     = state_r;
      started_nxt   = started_r;
      val_nxt       = val_r;
      left_nxt      = left_r;
      last_nxt      = last_r;
      part_nxt      = part_r;
      byte_nxt      = byte_r;
      fill_nxt      = fill_r;
      fld_ready_nxt = FLD_READY;
      oct_valid_nxt = OCT_VALID;
      oct_data_nxt  = OCT_DATA;
      oct_num_nxt   = OCT_NUM;
      oct_first_nxt = OCT_FIRST;
      oct_last_nxt  = OCT_LAST;
      oct_part_nxt  = OCT_PART;
      case (state_r)
         S_IDLE: begin
            fld_ready_nxt = 1'h1;
            // R12: field taken on handshake
            if (fld_acc) begin
               fld_ready_nxt = 1'h0;
               // R4: fields accepted strictly in order
               val_nxt   = FLD_VALUE;
               left_nxt  = FLD_WIDTH;
               last_nxt  = FLD_LAST;
               part_nxt  = FLD_PART;
               state_nxt = S_PACK;
            end
         end
         S_PACK: begin
            // R3: spill remaining bits onward
            byte_nxt = mrg_byte;
            fill_nxt = mrg_fill;
            val_nxt  = val_r >> take;
            left_nxt = left_after(left_r, take);
            if (close_now) begin
               // R7: header closes on a boundary
               // R10: completed octet handed down
               oct_valid_nxt = 1'h1;
               // R11: plain octet, no bit reordering
               oct_data_nxt  = mrg_byte;
               oct_num_nxt   = num;
               oct_first_nxt = ~started_r;
               // R1: message octets follow header
               oct_last_nxt  = fld_done & unit_end;
               oct_part_nxt  = part_r;
               started_nxt   = 1'h1;
               state_nxt     = S_EMIT;
            end else if (fld_done) begin
               // R5: next group joins contiguously
               fld_ready_nxt = 1'h1;
               state_nxt     = S_IDLE;
            end
         end
         S_EMIT: begin
            // R12: hold octet until sink takes it
            if (oct_acc) begin
               oct_valid_nxt = 1'h0;
               // R6: fresh octet starts all zero
               byte_nxt      = `APDU_OCTET_ZERO;
               fill_nxt      = FILL_NONE;
               if (OCT_LAST) begin
                  started_nxt = 1'h0;
               end
               // One bubble per octet keeps the merge path short
               if (left_r == LEFT_NONE) begin
                  fld_ready_nxt = 1'h1;
                  state_nxt     = S_IDLE;
               end else begin
                  state_nxt = S_PACK;
               end
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   // Controller registers
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_r   <= S_IDLE;
         started_r <= 1'h0;
      end else begin
         state_r   <= state_nxt;
         started_r <= started_nxt;
      end
   end

   // Field registers
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         val_r  <= {FW{1'h0}};
         left_r <= LEFT_NONE;
         last_r <= 1'h0;
         part_r <= `APDU_PART_HDR;
      end else begin
         val_r  <= val_nxt;
         left_r <= left_nxt;
         last_r <= last_nxt;
         part_r <= part_nxt;
      end
   end

   // Octet assembly registers
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         byte_r <= `APDU_OCTET_ZERO;
         fill_r <= FILL_NONE;
      end else begin
         byte_r <= byte_nxt;
         fill_r <= fill_nxt;
      end
   end

   // Source-side ready
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         FLD_READY <= 1'h0;
      end else begin
         FLD_READY <= fld_ready_nxt;
      end
   end

   // Sink-side outputs, all straight from flops
   always @(posedge CORE_CLK or negedge RST_N) begin
      if (!RST_N) begin
         OCT_VALID <= 1'h0;
         OCT_DATA  <= `APDU_OCTET_ZERO;
         OCT_NUM   <= {NW{1'h0}};
         OCT_FIRST <= 1'h0;
         OCT_LAST  <= 1'h0;
         OCT_PART  <= `APDU_PART_HDR;
      end else begin
         OCT_VALID <= oct_valid_nxt;
         OCT_DATA  <= oct_data_nxt;
         OCT_NUM   <= oct_num_nxt;
         OCT_FIRST <= oct_first_nxt;
         OCT_LAST  <= oct_last_nxt;
         OCT_PART  <= oct_part_nxt;
      end
   end
endmodule

// ---- verilog/apdu_map.vh ----
// Constants for the protocol data unit bit packer.
// Assumes inclusion by each design file that needs them.
`ifndef APDU_MAP_VH
`define APDU_MAP_VH

`define APDU_FIELD_MAX    32
`define APDU_WIDTH_BITS   6
`define APDU_OCTET_BITS   8
`define APDU_OCTNUM_BITS  16
`define APDU_FILL_BITS    4
`define APDU_OCTET_ZERO   8'h00
`define APDU_PART_HDR     1'h0
`define APDU_PART_MSG     1'h1

`endif

// ---- verilog/apdu_field_merge.v ----
// Merges one field chunk into the partial octet, LSB first.
// Purely combinational; caller limits take_cnt to free room.
`timescale 1ns/10ps
`include "apdu_map.vh"
module apdu_field_merge (
   // Current octet
   input  wire [7:0] cur_byte,
   input  wire [3:0] fill,
   // Chunk
   input  wire [7:0] chunk,
   input  wire [3:0] take_cnt,
   // Result
   output reg  [7:0] new_byte,
   output wire [3:0] new_fill
);
   integer i;
   assign new_fill = fill + take_cnt;

   always @* begin
      new_byte = cur_byte;
      for (i = 0; i < 8; i = i + 1) begin
         if ((i >= fill) && (i < fill + take_cnt)) begin
            new_byte[i] = chunk[i - fill];
         end
      end
   end
endmodule

// ---- verilog/apdu_octet_counter.v ----
// Octet sequence number, restarted for each data unit.
// Assumes inc pulses once per octet accepted downstream.
`timescale 1ns/10ps
`include "apdu_map.vh"
module apdu_octet_counter #(
   parameter W = `APDU_OCTNUM_BITS
) (
   // Clock and reset
   input  wire         clk,
   input  wire         rst_n,
   // Control
   input  wire         clear,
   input  wire         inc,
   // Count
   output reg  [W-1:0] count_r
);
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_r <= {W{1'h0}};
      end else if (clear) begin
         count_r <= {W{1'h0}};
      end else if (inc) begin
         count_r <= count_r + {{(W-1){1'h0}}, 1'h1};
      end
   end
endmodule

// ---- testbench/apdu_checker.sv ----
// Checker on the packer top ports.
// Assumes a bind from the bench top.
`timescale 1ns/10ps
module apdu_checker #(parameter NW = 16) (
   // Field side
   input wire          CORE_CLK,
   input wire          RST_N,
   input wire          FLD_VALID,
   input wire          FLD_READY,
   input wire          FLD_LAST,
   // Octet side
   input wire          OCT_VALID,
   input wire          OCT_READY,
   input wire [7:0]    OCT_DATA,
   input wire [NW-1:0] OCT_NUM,
   input wire          OCT_FIRST,
   input wire          OCT_LAST,
   input wire          OCT_PART
);
   logic [NW-1:0] num_r;
   logic          msg_r;
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RST_N);
   // Number and part the next octet must carry
   always_ff @(posedge CORE_CLK or negedge RST_N)
      if (!RST_N) begin
         num_r <= '0;
         msg_r <= 1'h0;
      end else if (OCT_VALID && OCT_READY) begin
         num_r <= OCT_LAST ? '0 : num_r + 1'h1;
         msg_r <= OCT_PART && !OCT_LAST;
      end
   AST_HOLD: assert property (OCT_VALID && !OCT_READY |=> OCT_VALID && $stable(OCT_DATA))
      else $error("octet changed while waiting");
   AST_NUM: assert property (OCT_VALID |-> OCT_NUM == num_r) else $error("octet number");
   AST_FIRST: assert property (OCT_VALID |-> OCT_FIRST == (OCT_NUM == '0)) else $error("first");
   AST_START: assert property (OCT_VALID && OCT_FIRST |-> !OCT_PART) else $error("start");
   AST_ORDER: assert property (OCT_VALID && msg_r |-> OCT_PART) else $error("order");
   AST_END: assert property (OCT_VALID && OCT_LAST |-> OCT_PART) else $error("end");
   AST_TAKE: assert property (FLD_VALID && FLD_READY |=> !FLD_READY) else $error("take");
   AST_FLUSH: assert property (FLD_VALID && FLD_READY && FLD_LAST |-> ##[1:12] OCT_VALID)
      else $error("no octet after last field");
   cover property (OCT_VALID && OCT_READY && OCT_LAST);
   cover property (OCT_VALID && !OCT_READY);
   cover property (FLD_VALID && FLD_READY && FLD_LAST);
endmodule

// ---- testbench/apdu_sink_model.sv ----
// Lower layer taking octets, prompt or stalling every other cycle.
// Assumes the bench picks the pace with slow.
`timescale 1ns/10ps
module apdu_sink_model (
   // Control
   input  wire  clk,
   input  wire  rst_n,
   input  wire  slow,
   // Octet handshake
   input  wire  oct_valid,
   output logic oct_ready
);
   logic tick_r;
   always @(posedge clk or negedge rst_n)
      if (!rst_n) tick_r <= 1'h0;
      else if (oct_valid) tick_r <= ~tick_r;
   assign oct_ready = rst_n && (!slow || tick_r);
endmodule

// ---- testbench/apdu_packer_tb_top.sv ----
// Bench top: field source and octet checks around the packer.
// Assumes the design, checker and sink model are compiled first.
`timescale 1ns/10ps
module apdu_packer_tb_top;
   logic        clk = 1'h0, rst_n = 1'h0, vld = 1'h0, part = 1'h0, last = 1'h0, slow = 1'h0;
   logic [5:0]  wid = 6'h1;
   logic [31:0] val = 32'h0;
   logic [15:0] n = 16'h0;
   logic        eb[$];
   logic [26:0] exq[$], gq[$];
   int          fail_count = 0, checks = 0;
   wire         f_rdy, o_vld, o_rdy, o_first, o_last, o_part;
   wire  [7:0]  o_dat;
   wire  [15:0] o_num;

   apdu_packer dut_u (.CORE_CLK(clk), .RST_N(rst_n), .FLD_VALID(vld), .FLD_READY(f_rdy),
      .FLD_VALUE(val), .FLD_WIDTH(wid), .FLD_PART(part), .FLD_LAST(last), .OCT_VALID(o_vld),
      .OCT_READY(o_rdy), .OCT_DATA(o_dat), .OCT_NUM(o_num), .OCT_FIRST(o_first),
      .OCT_LAST(o_last), .OCT_PART(o_part));
   apdu_sink_model sink_u (.clk(clk), .rst_n(rst_n), .slow(slow), .oct_valid(o_vld),
      .oct_ready(o_rdy));

   initial forever #2 clk = ~clk;
   always @(posedge clk) if (o_vld && o_rdy) gq.push_back({o_num, o_first, o_last, o_part, o_dat});

   task automatic chk(input logic [26:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Reference packing runs alongside; a part's octets are queued at its last field
   task automatic send(input logic p, l, input logic [5:0] w, input logic [31:0] v);
      int         i;
      logic [7:0] b;
      for (i = 0; i < w; i++) eb.push_back(v[i]);
      while (l && eb.size() % 8) eb.push_back(1'h0);
      while (l && eb.size()) begin
         for (i = 0; i < 8; i++) b[i] = eb.pop_front();
         exq.push_back({n, n == 16'h0, p && eb.size() == 0, p, b});
         n = (p && eb.size() == 0) ? 16'h0 : n + 16'h1;
      end
      @(posedge clk) #1;
      {vld, part, last, wid, val} = {1'h1, p, l, w, v};
      for (i = 0; i < 99 && !f_rdy; i++) @(posedge clk) #1;
      @(posedge clk) #1;
      vld = 1'h0;
   endtask

   task automatic judge;
      // Look past the edge so the monitor has logged the last octet
      for (int i = 0; i < 999 && gq.size() < exq.size(); i++) @(posedge clk) #1;
      chk(27'(gq.size()), 27'(exq.size()));
      while (exq.size() && gq.size()) chk(gq.pop_front(), exq.pop_front());
      gq.delete();
      exq.delete();
   endtask

   // Example header with two grouped fields, prompt sink
   task automatic t_table;
      slow = 1'h0;
      send(0, 0, 4, 32'h1); send(0, 0, 1, 32'h0); send(0, 0, 1, 32'h1); send(0, 0, 1, 32'h1);
      send(0, 0, 24, 32'h17); send(0, 0, 1, 32'h0); send(0, 0, 1, 32'h1); send(0, 0, 1, 32'h0);
      send(0, 0, 1, 32'h1); send(0, 1, 24, 32'h7C);
      send(1, 0, 8, 32'hA5); send(1, 1, 8, 32'h3C);
      judge;
   endtask

   // Wide field, boundary ending header, stray high bits, then a second unit
   task automatic t_wide;
      slow = 1'h1;
      send(0, 0, 3, 32'hFFFFFFFD); send(0, 0, 32, 32'h89ABCDEF); send(0, 1, 5, 32'h0);
      send(1, 0, 8, 32'h5A); send(1, 0, 8, 32'hC3); send(1, 1, 8, 32'h01);
      send(0, 1, 1, 32'h1); send(1, 1, 8, 32'h80);
      judge;
   endtask

   task stop_test;
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge clk);
      #1 rst_n = 1'h1;
      t_table;
      t_wide;
      stop_test;
   end
   initial begin
      #20000;
      fail_count++;
      stop_test;
   end
endmodule

bind apdu_packer apdu_checker #(.NW(NW)) chk_u (.CORE_CLK, .RST_N, .FLD_VALID, .FLD_READY,
   .FLD_LAST, .OCT_VALID, .OCT_READY, .OCT_DATA, .OCT_NUM, .OCT_FIRST, .OCT_LAST, .OCT_PART);
